// [rtl/rpsm_matrix.sv]
// Function
// - each input selector register carries two independent six-bit peripheral input fields
// - input field value n routes remappable pin n to that peripheral input
// - input values are valid only up to the pins this variant implements
// - fields exist for interrupts, captures, faults, spi, timer clocks, uart rx/cts
// - each output selector register carries two six-bit fields, one per output pin
// - output code selects driver: 1-2 comparators, 18-25 and 35 compare outputs
// - output code zero is the null function, pin left undriven
// - uart transmit/rts codes: 3-4, 5-6, 28-29, 30-31
// - spi data/clock/select codes: 7-12 for ports 1-2, 32-34 for port 3
// - reset loads the null function into every output selection
// - infrared bit clock travels on the uart request-to-send output code
// - one pin may feed many inputs, one output may drive many pins
// - contention impossible by structure; no other hardware lockouts
// - input values naming absent pins, or above 45, leave input unmapped
// - output fields of absent pins are not implemented, writes ignored
// - at most 46 remappable pins, 14 of them input only
// - six-bit code spans 64 pins, only a subset implemented
// - write-lock sequence, shadow monitoring and one-way lock protect the map
// - while locked, selector writes complete but leave contents unchanged
// - reset sets input fields to all ones (ground) and outputs to zero
// - shadow copies watch the selectors; unexpected change requests mismatch reset
package rpsm_pkg;
    localparam int SEL_W = 6;
    localparam int N_IN_FN = 37;
    localparam int N_IO_PINS = 32;
    localparam int N_PINS = 46;
    localparam int N_CODES = 36;
    localparam logic [5:0] IN_RST = 6'h3f;
    localparam logic [5:0] OUT_NULL = 6'h00;
    localparam logic [5:0] MAX_PIN = 6'h2d;
    // input function indices, table order
    localparam int FN_EXT_INT = 0;
    localparam int FN_CAPTURE = 4;
    localparam int FN_FAULT_A = 13;
    localparam int FN_FAULT_B = 14;
    localparam int FN_SPI = 15;
    localparam int FN_TIMER = 24;
    localparam int FN_UART = 29;
    // output function codes
    localparam logic [5:0] CODE_CMP1 = 6'h01;
    localparam logic [5:0] CODE_UART_LO = 6'h03;
    localparam logic [5:0] CODE_SPI_HI = 6'h0c;
    localparam logic [5:0] CODE_CMPO_LO = 6'h12;
    localparam logic [5:0] CODE_CMPO_HI = 6'h19;
    localparam logic [5:0] CODE_UART34_LO = 6'h1c;
    localparam logic [5:0] CODE_CMPO9 = 6'h23;
    // oscillator control keys and lock bit position
    localparam logic [7:0] OSC_KEY1 = 8'h46;
    localparam logic [7:0] OSC_KEY2 = 8'h57;
    localparam int LOCK_POS = 6;
endpackage

`timescale 1ns/1ns
module rpsm_matrix #(
    parameter int N_IN = rpsm_pkg::N_IN_FN,
    parameter int N_IO = rpsm_pkg::N_IO_PINS,
    parameter int N_PIN = rpsm_pkg::N_PINS,
    parameter logic [rpsm_pkg::N_PINS-1:0] PIN_PRESENT = {rpsm_pkg::N_PINS{1'b1}},
    parameter logic [rpsm_pkg::N_IO_PINS-1:0] OUT_PRESENT = {rpsm_pkg::N_IO_PINS{1'b1}}
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_bank_i,
    input wire logic [5:0] cfg_idx_i,
    input wire logic [5:0] cfg_data_i,
    input wire logic cfg_rd_bank_i,
    input wire logic [5:0] cfg_rd_idx_i,
    output logic [5:0] cfg_rd_data_o,
    input wire logic osc_wr_i,
    input wire logic [7:0] osc_wr_data_i,
    input wire logic one_way_lock_i,
    output logic map_write_lock_bit_o,
    output logic mismatch_reset_o,
    input wire logic [N_PIN-1:0] pin_in_i,
    output logic [N_IN-1:0] periph_in_o,
    input wire logic [rpsm_pkg::N_CODES-1:0] periph_out_i,
    output logic [N_IO-1:0] pin_out_o,
    output logic [N_IO-1:0] pin_oe_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_HALF, SEQ_OPEN} rpsm_seq_t;

    typedef struct packed {
        logic [N_IO-1:0][5:0] out_sel;
        logic [N_IN-1:0][5:0] in_sel;
        rpsm_seq_t seq;
        logic lock;
        logic locked_once;
        logic [5:0] rd_data;
        logic [N_IN-1:0] periph_in;
        logic [N_IO-1:0] pin_out;
        logic [N_IO-1:0] pin_oe;
    } rpsm_state_t;

    localparam int CFG_W = (N_IN + N_IO) * rpsm_pkg::SEL_W;
    localparam logic [CFG_W-1:0] CFG_RST = {{N_IO{rpsm_pkg::OUT_NULL}}, {N_IN{rpsm_pkg::IN_RST}}};

    rpsm_state_t st_ff;
    rpsm_state_t nxt_st;
    logic commit;
    logic [CFG_W-1:0] nxt_cfg;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // an output code with an assigned function; gaps behave as null
    function automatic logic code_valid(input logic [5:0] code);
        code_valid = (code >= rpsm_pkg::CODE_CMP1 && code <= rpsm_pkg::CODE_SPI_HI) ||
                     (code >= rpsm_pkg::CODE_CMPO_LO && code <= rpsm_pkg::CODE_CMPO_HI) ||
                     (code >= rpsm_pkg::CODE_UART34_LO && code <= rpsm_pkg::CODE_CMPO9);
    endfunction

    // an input selector naming a pin that exists on this variant
    function automatic logic pin_valid(input logic [5:0] sel);
        pin_valid = (sel <= rpsm_pkg::MAX_PIN) && (int'(sel) < N_PIN) && PIN_PRESENT[sel];
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // one field per input and per pin, so two drivers can never meet
    always_comb
    begin
        nxt_st = st_ff;
        commit = 1'b0;
        // selector writes silently dropped while locked
        if (cfg_wr_i && !st_ff.lock)
        begin
            if (!cfg_bank_i && int'(cfg_idx_i) < N_IN)
            begin
                nxt_st.in_sel[cfg_idx_i] = cfg_data_i;
                commit = 1'b1;
            end
            else if (cfg_bank_i && int'(cfg_idx_i) < N_IO && OUT_PRESENT[cfg_idx_i[4:0]])
            begin
                nxt_st.out_sel[cfg_idx_i] = cfg_data_i;
                commit = 1'b1;
            end
        end
        // unlock keys, then exactly one update of the lock bit
        if (osc_wr_i)
        begin
            case (st_ff.seq)
                SEQ_IDLE:
                begin
                    nxt_st.seq = (osc_wr_data_i == rpsm_pkg::OSC_KEY1) ? SEQ_HALF : SEQ_IDLE;
                end
                SEQ_HALF:
                begin
                    nxt_st.seq = (osc_wr_data_i == rpsm_pkg::OSC_KEY2) ? SEQ_OPEN : SEQ_IDLE;
                end
                SEQ_OPEN:
                begin
                    nxt_st.seq = SEQ_IDLE;
                    // one-way option: setting always works, clearing is refused once set
                    if (osc_wr_data_i[rpsm_pkg::LOCK_POS] || !(one_way_lock_i && st_ff.locked_once))
                    begin
                        nxt_st.lock = osc_wr_data_i[rpsm_pkg::LOCK_POS];
                    end
                    if (osc_wr_data_i[rpsm_pkg::LOCK_POS])
                    begin
                        nxt_st.locked_once = 1'b1;
                    end
                end
                default:
                begin
                    nxt_st.seq = SEQ_IDLE;
                end
            endcase
        end
        // readback; absent output fields read zero
        if (!cfg_rd_bank_i)
        begin
            nxt_st.rd_data = (int'(cfg_rd_idx_i) < N_IN) ? st_ff.in_sel[cfg_rd_idx_i] : 6'h00;
        end
        else
        begin
            nxt_st.rd_data = (int'(cfg_rd_idx_i) < N_IO) ? st_ff.out_sel[cfg_rd_idx_i] : 6'h00;
        end
        // input routing: per peripheral, one pin may fan out to many inputs
        for (int f = 0; f < N_IN; f++)
        begin
            nxt_st.periph_in[f] = 1'b0;
            if (pin_valid(st_ff.in_sel[f]))
            begin
                nxt_st.periph_in[f] = pin_in_i[st_ff.in_sel[f]];
            end
        end
        // output routing: per pin, code indexes the peripheral output
        for (int p = 0; p < N_IO; p++)
        begin
            // rts codes also carry the infrared bit clock from the uart
            nxt_st.pin_oe[p] = OUT_PRESENT[p] && code_valid(st_ff.out_sel[p]);
            nxt_st.pin_out[p] = 1'b0;
            if (nxt_st.pin_oe[p])
            begin
                nxt_st.pin_out[p] = periph_out_i[st_ff.out_sel[p]];
            end
        end
        // selector reset: inputs to ground, outputs to null
        if (rst_i)
        begin
            nxt_st = '0;
            nxt_st.seq = SEQ_IDLE;
            {nxt_st.out_sel, nxt_st.in_sel} = CFG_RST;
            commit = 1'b0;
        end
        nxt_cfg = {nxt_st.out_sel, nxt_st.in_sel};
    end

    always_ff @(posedge ref_clk_i)
    begin
        st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // shadow monitor
    // ----------------------------------------------------------------
    rpsm_shadow #(
        .W(CFG_W),
        .RST_VAL(CFG_RST)
    ) u_shadow (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .load_i(commit),
        .exp_i(nxt_cfg),
        .cfg_i({st_ff.out_sel, st_ff.in_sel}),
        .mismatch_o(mismatch_reset_o)
    );

    assign cfg_rd_data_o = st_ff.rd_data;
    assign map_write_lock_bit_o = st_ff.lock;
    assign periph_in_o = st_ff.periph_in;
    assign pin_out_o = st_ff.pin_out;
    assign pin_oe_o = st_ff.pin_oe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_key_pair;
        osc_wr_i && osc_wr_data_i == rpsm_pkg::OSC_KEY1 ##1
        osc_wr_i && osc_wr_data_i == rpsm_pkg::OSC_KEY2;
    endsequence

    sequence s_free_update;
        osc_wr_i && (osc_wr_data_i[rpsm_pkg::LOCK_POS] ||
            !(one_way_lock_i && st_ff.locked_once));
    endsequence

    reset_null_out_a: assert property (@(posedge ref_clk_i)
        rst_i |=> (pin_oe_o == '0 && st_ff.out_sel == '0))
        else $error("outputs not null after reset");

    reset_in_gnd_a: assert property (@(posedge ref_clk_i)
        rst_i |=> (periph_in_o == '0))
        else $error("inputs not grounded after reset");

    locked_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cfg_wr_i && map_write_lock_bit_o) |=> $stable({st_ff.out_sel, st_ff.in_sel}))
        else $error("selector changed while locked");

    open_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cfg_wr_i && !map_write_lock_bit_o && !cfg_bank_i && int'(cfg_idx_i) < N_IN)
        |=> st_ff.in_sel[$past(cfg_idx_i)] == $past(cfg_data_i))
        else $error("input field write lost");

    unlock_update_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_ff.seq == SEQ_IDLE) ##0 s_key_pair ##1 s_free_update
        |=> map_write_lock_bit_o == $past(osc_wr_data_i[rpsm_pkg::LOCK_POS]))
        else $error("lock not updated after key pair");

    no_key_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_ff.seq != SEQ_OPEN) |=> $stable(map_write_lock_bit_o))
        else $error("lock changed without keys");

    one_way_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (one_way_lock_i && st_ff.locked_once && map_write_lock_bit_o)
        |=> map_write_lock_bit_o)
        else $error("one-way lock cleared");

    generate
        for (genvar g = 0; g < N_IO; g++)
        begin : g_out_chk
            null_code_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
                !code_valid(st_ff.out_sel[g]) |=> !pin_oe_o[g] && !pin_out_o[g])
                else $error("unassigned code drives pin");
            drive_code_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
                (OUT_PRESENT[g] && code_valid(st_ff.out_sel[g]))
                |=> pin_oe_o[g] && pin_out_o[g] == $past(periph_out_i[st_ff.out_sel[g]]))
                else $error("pin not driven by selected output");
        end
        for (genvar h = 0; h < N_IN; h++)
        begin : g_in_chk
            bad_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
                !pin_valid(st_ff.in_sel[h]) |=> !periph_in_o[h])
                else $error("invalid selector mapped an input");
            route_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
                pin_valid(st_ff.in_sel[h]) |=> periph_in_o[h] == $past(pin_in_i[st_ff.in_sel[h]]))
                else $error("input not routed from selected pin");
        end
    endgenerate

endmodule

// [rtl/rpsm_shadow.sv]
`timescale 1ns/1ns
module rpsm_shadow #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] exp_i,
    input wire logic [W-1:0] cfg_i,
    output logic mismatch_o
);

    // ----------------------------------------------------------------
    // shadow copy and mismatch flag
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] copy;
        logic mismatch;
    } rpsm_shadow_t;

    rpsm_shadow_t sh_ff;
    rpsm_shadow_t nxt_sh;

    // copy follows only legal writes, so a disturbed cell shows as a difference
    always_comb
    begin
        nxt_sh = sh_ff;
        if (load_i)
        begin
            nxt_sh.copy = exp_i;
        end
        // sticky until reset: the request must not vanish before it is served
        if (cfg_i != sh_ff.copy)
        begin
            nxt_sh.mismatch = 1'b1;
        end
        if (rst_i)
        begin
            nxt_sh.copy = RST_VAL;
            nxt_sh.mismatch = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        sh_ff <= nxt_sh;
    end

    assign mismatch_o = sh_ff.mismatch;

    mismatch_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cfg_i != sh_ff.copy) |=> mismatch_o [*2])
        else $error("mismatch not flagged");

endmodule

// [tb/rpsm_far_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// peripherals and pins around the matrix
// ----------------------------------------
module rpsm_far_model (
    input wire logic [5:0] code_i,
    input wire logic code_lvl_i,
    input wire logic [5:0] pin_i,
    input wire logic pin_lvl_i,
    output logic [35:0] periph_out_o,
    output logic [45:0] pin_in_o
);
    // the chosen source shows the level, every other the inverse, so a misroute shows
    always_comb
    begin
        periph_out_o = {36{~code_lvl_i}};
        pin_in_o = {46{~pin_lvl_i}};
        if (code_i < 6'h24)
            periph_out_o[code_i] = code_lvl_i;
        if (pin_i < 6'h2e)
            pin_in_o[pin_i] = pin_lvl_i;
    end
endmodule

// [tb/test_remappable_pin_select_matrix.sv]
`timescale 1ns/1ns
// ----------------------------------------
// self-checking bench for the pin matrix
// ----------------------------------------
module test_remappable_pin_select_matrix;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cfg_wr = 1'b0;
    logic cfg_bank = 1'b0;
    logic [5:0] cfg_idx = 6'h00;
    logic [5:0] cfg_data = 6'h00;
    logic rd_bank = 1'b0;
    logic [5:0] rd_idx = 6'h00;
    logic osc_wr = 1'b0;
    logic [7:0] osc_data = 8'h00;
    logic one_way = 1'b0;
    logic [5:0] code = 6'h00;
    logic code_lvl = 1'b0;
    logic [5:0] pin = 6'h00;
    logic pin_lvl = 1'b0;
    logic [5:0] rd_data;
    logic lock;
    logic mism;
    logic [45:0] pin_in;
    logic [36:0] periph_in;
    logic [35:0] periph_out;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    // pin 44 and output pin 31 absent, so refusal of absent pins is seen
    rpsm_matrix #(
        .PIN_PRESENT({1'b1, 1'b0, {44{1'b1}}}),
        .OUT_PRESENT({1'b0, {31{1'b1}}})
    ) dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr), .cfg_bank_i(cfg_bank),
        .cfg_idx_i(cfg_idx), .cfg_data_i(cfg_data), .cfg_rd_bank_i(rd_bank),
        .cfg_rd_idx_i(rd_idx), .cfg_rd_data_o(rd_data), .osc_wr_i(osc_wr),
        .osc_wr_data_i(osc_data), .one_way_lock_i(one_way), .map_write_lock_bit_o(lock),
        .mismatch_reset_o(mism), .pin_in_i(pin_in), .periph_in_o(periph_in),
        .periph_out_i(periph_out), .pin_out_o(pin_out), .pin_oe_o(pin_oe)
    );

    rpsm_far_model fm_u (
        .code_i(code), .code_lvl_i(code_lvl), .pin_i(pin), .pin_lvl_i(pin_lvl),
        .periph_out_o(periph_out), .pin_in_o(pin_in)
    );

    function automatic logic code_ok(input logic [5:0] c);
        return (c >= 6'h01 && c <= 6'h0c) || (c >= 6'h12 && c <= 6'h19)
            || (c >= 6'h1c && c <= 6'h23);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk(input logic [69:0] seen, input logic [69:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wsel(input logic b, input logic [5:0] i, input logic [5:0] d);
        @(posedge ref_clk_i);
        cfg_wr <= 1'b1;
        cfg_bank <= b;
        cfg_idx <= i;
        cfg_data <= d;
        @(posedge ref_clk_i);
        cfg_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic b, input logic [5:0] i, input logic [5:0] exp);
        @(posedge ref_clk_i);
        rd_bank <= b;
        rd_idx <= i;
        tick(3);
        chk(rd_data, exp);
    endtask

    task automatic osc(input logic [7:0] b);
        @(posedge ref_clk_i);
        osc_wr <= 1'b1;
        osc_data <= b;
        @(posedge ref_clk_i);
        osc_wr <= 1'b0;
    endtask

    // both keys on back-to-back cycles, then the lock byte as one write
    task automatic lseq(input logic [7:0] b);
        @(posedge ref_clk_i);
        osc_wr <= 1'b1;
        osc_data <= 8'h46;
        @(posedge ref_clk_i);
        osc_data <= 8'h57;
        @(posedge ref_clk_i);
        osc_data <= b;
        @(posedge ref_clk_i);
        osc_wr <= 1'b0;
        tick(1);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // whole run is near 1500 cycles; the ceiling leaves wide margin
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        tick(1);
        chk({pin_oe, periph_in, mism}, 70'h0);
        rdchk(1'b0, 6'h05, 6'h3f);
        rdchk(1'b1, 6'h07, 6'h00);
        // function f listens to pin f+9; pin 44 is absent so f=35 stays low
        for (int f = 0; f < 37; f++)
        begin
            wsel(1'b0, f[5:0], f[5:0] + 6'h09);
            pin <= f[5:0] + 6'h09;
            rdchk(1'b0, f[5:0], f[5:0] + 6'h09);
            for (int l = 1; l >= 0; l--)
            begin
                @(posedge ref_clk_i) pin_lvl <= l[0];
                tick(3);
                chk(periph_in[f], (f == 35) ? 1'b0 : l[0]);
            end
        end
        // pin 0 low, every other pin high: out-of-range selectors must read low
        wsel(1'b0, 6'h00, 6'h2e);
        pin <= 6'h00;
        tick(3);
        chk(periph_in[0], 1'b0);
        wsel(1'b0, 6'h00, 6'h3f);
        tick(3);
        chk(periph_in[0], 1'b0);
        // one pin feeding three inputs
        wsel(1'b0, 6'h00, 6'h2d);
        wsel(1'b0, 6'h01, 6'h2d);
        pin <= 6'h2d;
        for (int l = 1; l >= 0; l--)
        begin
            @(posedge ref_clk_i) pin_lvl <= l[0];
            tick(3);
            chk({periph_in[36], periph_in[1:0]}, {3{l[0]}});
        end
        // every code on pin 3, source high then low
        for (int c = 0; c < 64; c++)
        begin
            wsel(1'b1, 6'h03, c[5:0]);
            code <= c[5:0];
            rdchk(1'b1, 6'h03, c[5:0]);
            for (int l = 1; l >= 0; l--)
            begin
                @(posedge ref_clk_i) code_lvl <= l[0];
                tick(3);
                chk({pin_oe[3], pin_out[3]}, {code_ok(c[5:0]), code_ok(c[5:0]) & l[0]});
            end
        end
        // one output on two pins; the absent pin ignores its write
        wsel(1'b1, 6'h1e, 6'h04);
        wsel(1'b1, 6'h03, 6'h04);
        wsel(1'b1, 6'h1f, 6'h04);
        code <= 6'h04;
        @(posedge ref_clk_i) code_lvl <= 1'b1;
        tick(3);
        chk({pin_out[31:30], pin_out[3], pin_oe[31]}, 4'h6);
        rdchk(1'b1, 6'h1f, 6'h00);
        // locked writes are swallowed; a wrong key leaves the lock alone
        lseq(8'h40);
        chk(lock, 1'b1);
        wsel(1'b1, 6'h03, 6'h00);
        rdchk(1'b1, 6'h03, 6'h04);
        lseq(8'h00);
        chk(lock, 1'b0);
        osc(8'h46);
        osc(8'h12);
        osc(8'h40);
        tick(1);
        chk(lock, 1'b0);
        wsel(1'b1, 6'h03, 6'h00);
        rdchk(1'b1, 6'h03, 6'h00);
        // one-way lock cannot be undone short of reset
        @(posedge ref_clk_i) one_way <= 1'b1;
        lseq(8'h40);
        lseq(8'h00);
        chk({lock, mism}, 2'h2);
        @(posedge ref_clk_i) rst_i <= 1'b1;
        tick(2);
        @(posedge ref_clk_i) rst_i <= 1'b0;
        tick(1);
        chk({lock, pin_oe}, 33'h0);
        rdchk(1'b1, 6'h1e, 6'h00);
        test_done();
    end
endmodule
